// ===== core/spl_bert_chk.sv
// spl_bert_chk: test pattern checker of one port; observes only.
// assumes chk_valid pulses once per observed bit.
module spl_bert_chk
	import spl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	spl_bert_if.chk  bert
);
	typedef struct packed {
		logic [30:0] ref_q;
		logic        sync;
		logic [5:0]  run;
		logic [2:0]  errs;
		logic        err;
		logic        loss;
	} spl_chk_st_t;

	spl_chk_st_t st;
	spl_chk_st_t next_st;
	logic        pred;

	assign pred = spl_prbs_fb(st.ref_q, bert.pattern);

	// ------------------------------------------------------------
	// hunt by loading received bits, then free-run and compare
	// ------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.err  = 1'b0;
		next_st.loss = 1'b0;
		if (bert.chk_valid && !st.sync) begin
			next_st.ref_q = {st.ref_q[29:0], bert.chk_bit};
			next_st.run   = (bert.chk_bit == pred) ? st.run + 6'h01 : 6'h00;
			if (bert.chk_bit == pred && st.run == CHK_SYNC_RUN - 6'h01) begin
				next_st.sync = 1'b1;
				next_st.errs = 3'h0;
			end
		end else if (bert.chk_valid) begin
			next_st.ref_q = {st.ref_q[29:0], pred};
			if (bert.chk_bit != pred) begin
				next_st.err  = 1'b1;
				next_st.errs = st.errs + 3'h1;
				if (st.errs == CHK_LOSS_ERRS - 3'h1) begin
					next_st.sync = 1'b0;
					next_st.loss = 1'b1;
					next_st.run  = 6'h00;
				end
			end else begin
				next_st.errs = 3'h0;
			end
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bert.chk_sync = st.sync;
	assign bert.chk_err  = st.err;
	assign bert.chk_loss = st.loss;

	bit_compare_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st.sync && bert.chk_valid && bert.chk_bit != pred) |=> bert.chk_err)
		else $error("mismatch in sync not counted");
endmodule

// ===== core/spl_bert_gen.sv
// spl_bert_gen: test pattern generator of one port.
// assumes gen_adv pulses once per transmitted bit.
module spl_bert_gen
	import spl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	spl_bert_if.gen  bert
);
	typedef struct packed {
		logic [30:0] lfsr;
		logic        inj;
	} spl_gen_st_t;

	spl_gen_st_t st;
	spl_gen_st_t next_st;

	// ------------------------------------------------------------
	// pattern shift and one-bit error insertion
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (bert.gen_inject) begin
			next_st.inj = 1'b1;
		end
		if (bert.gen_adv) begin
			next_st.lfsr = {st.lfsr[29:0], spl_prbs_fb(st.lfsr, bert.pattern)};
			next_st.inj  = bert.gen_inject; // flipped bit consumed
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st <= '{lfsr: 31'h7fff_ffff, inj: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign bert.gen_bit = st.lfsr[0] ^ st.inj;

	inject_flip_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(bert.gen_inject && !bert.gen_adv) |=> (bert.gen_bit != st.lfsr[0]))
		else $error("injected error not applied to generator output");
endmodule

// ===== core/spl_bert_if.sv
// spl_bert_if: link between the port core and its test pattern
// generator and checker. assumes all users share one clock.
interface spl_bert_if;
	import spl_pkg::*;
	spl_pat_t pattern;
	logic     gen_adv;
	logic     gen_inject;
	logic     gen_bit;
	logic     chk_valid;
	logic     chk_bit;
	logic     chk_sync;
	logic     chk_err;
	logic     chk_loss;
	modport core (output pattern, gen_adv, gen_inject, chk_valid, chk_bit,
		input gen_bit, chk_sync, chk_err, chk_loss);
	modport gen (input pattern, gen_adv, gen_inject, output gen_bit);
	modport chk (input pattern, chk_valid, chk_bit, output chk_sync, chk_err, chk_loss);
endinterface

// ===== core/spl_pkg.sv
// spl_pkg: register map, field positions, reset values, modes and the
// pattern feedback function of the serial port loop and test datapath.
// assumes a 32-bit classic wishbone slave with byte addresses.
package spl_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_CMD      = 8'h04;
	localparam logic [7:0] ADR_BUFCFG   = 8'h08;
	localparam logic [7:0] ADR_PKTCFG   = 8'h0c;
	localparam logic [7:0] ADR_STATUS   = 8'h10;
	localparam logic [7:0] ADR_CNT_BASE = 8'h14;
	localparam logic [7:0] ADR_CNT_END  = 8'h34;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_LOOP_LSB  = 0;
	localparam int CTRL_TXDIR_LSB = 2;
	localparam int CTRL_RXDIR_LSB = 4;
	localparam int CTRL_PAT_LSB   = 6;
	localparam int CTRL_EN_BIT    = 10;
	localparam int CMD_RECENTER   = 0;
	localparam int CMD_INJECT     = 1;
	localparam int CMD_CLEAR      = 2;
	localparam int CMD_DELETE     = 3;

	// ------------------------------------------------------------
	// reset values: pattern 2^15-1, target 4, max 16, starve 5,
	// 256-bit packets, fill byte all ones
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST   = 32'h0000_0100;
	localparam logic [31:0] BUFCFG_RST = 32'h0005_1004;
	localparam logic [31:0] PKTCFG_RST = 32'h00ff_0100;

	// ------------------------------------------------------------
	// statistics counter indices
	// ------------------------------------------------------------
	localparam int CNT_MISSING  = 0;
	localparam int CNT_LATE     = 1;
	localparam int CNT_RECENTER = 2;
	localparam int CNT_UNDER    = 3;
	localparam int CNT_OVER     = 4;
	localparam int CNT_STARVE   = 5;
	localparam int CNT_BERR     = 6;
	localparam int CNT_BLOSS    = 7;
	localparam int CNT_NUM      = 8;

	// checker: matches needed for sync, consecutive errors for loss
	localparam logic [5:0] CHK_SYNC_RUN  = 6'h20;
	localparam logic [2:0] CHK_LOSS_ERRS = 3'h4;

	typedef enum logic [1:0] {LOOP_NONE, LOOP_TOWARD_NETWORK, LOOP_TOWARD_SERIAL} spl_loop_t;
	typedef enum logic [1:0] {DIR_OFF, DIR_NET, DIR_SERIAL} spl_dir_t;
	typedef enum logic [3:0] {
		PAT_MARK, PAT_ALTERNATING, PAT_511, PAT_2047, PAT_2E15,
		PAT_2E20, PAT_2E23, PAT_2E29, PAT_2E31
	} spl_pat_t;

	// feedback bit of the pattern shift register, newest bit in r[0]
	function automatic logic spl_prbs_fb(input logic [30:0] r, input spl_pat_t p);
		case (p)
			PAT_MARK:        return 1'b1;
			PAT_ALTERNATING: return ~r[0];
			PAT_511:         return r[8] ^ r[4];
			PAT_2047:        return r[10] ^ r[8];
			PAT_2E15:        return r[14] ^ r[13];
			PAT_2E20:        return r[19] ^ r[2];
			PAT_2E23:        return r[22] ^ r[17];
			PAT_2E29:        return r[28] ^ r[26];
			PAT_2E31:        return r[30] ^ r[27];
			default:         return 1'b1;
		endcase
	endfunction

endpackage

// ===== core/spl_port_core.sv
// spl_port_core: one serial port's packet playout, fill substitution,
// loops, statistics and bit error test, behind a wishbone slave.
// assumes inputs synchronous to clk_in; the packet buffer itself lives
// outside and is steered by take and recenter pulses.
// Notes on behaviour
// - missing packet slot plays the fill pattern
// - fill lasts one packet of bits unless a recenter restarts the slot
// - late packet counts missing and late
// - recenter sets buffer depth to target
// - recenter causes one slot realignment only
// - delete disables, next register write takes defaults in its unwritten bytes
// - no-loop restores normal flow both ways
// - network loop returns network data, still delivered
// - network loop blocks serial data toward network
// - serial loop returns serial data, still forwarded
// - serial loop blocks network data toward serial
// - each port has own generator and checker
// - injection replaces user data one direction only
// - checker only observes, never alters traffic
// - mark, alternating and seven pseudorandom patterns
// - clear command zeroes all statistics counters, except one with an event in the clear cycle, which reads 1
// - missing run above threshold counts starvation
// - auto recenter on underflow or overflow, counted
// - error inject flips one generated bit
module spl_port_core
	import spl_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output wire logic [31:0] wb_dat_out,
	output wire logic        wb_ack_out,
	input  wire logic        ser_rx_valid_in,
	input  wire logic        ser_rx_bit_in,
	input  wire logic        ser_tx_req_in,
	output wire logic        ser_tx_valid_out,
	output wire logic        ser_tx_bit_out,
	input  wire logic        net_rx_bit_in,
	input  wire logic        net_pkt_arrive_in,
	input  wire logic        net_late_in,
	output wire logic        net_pkt_take_out,
	output wire logic        net_tx_valid_out,
	output wire logic        net_tx_bit_out,
	output wire logic        buf_recenter_out,
	output wire logic        port_active_out
);
	typedef enum logic {PLAY_DATA, PLAY_FILL} spl_play_t;

	typedef struct packed {
		spl_loop_t                         loop;
		spl_dir_t                          txdir;
		spl_dir_t                          rxdir;
		spl_pat_t                          pat;
		logic                              en;
		logic                              del_pend;
		logic [7:0]                        target;
		logic [7:0]                        maxd;
		logic [7:0]                        thr;
		logic [15:0]                       pkt_bits;
		logic [7:0]                        fill;
		logic [7:0]                        depth;
		spl_play_t                         play;
		logic [15:0]                       bitcnt;
		logic [7:0]                        miss_run;
		logic [CNT_NUM-1:0][CNT_W-1:0]     cnt;
		logic                              ack;
		logic [31:0]                       rdata;
		logic                              ser_last;
		logic                              ser_tx_valid;
		logic                              ser_tx_bit;
		logic                              net_tx_valid;
		logic                              net_tx_bit;
		logic                              take;
		logic                              recenter;
	} spl_core_st_t;

	spl_core_st_t         st;
	spl_core_st_t         next_st;
	spl_bert_if           bert ();
	logic                 acc;
	logic                 wr;
	logic                 cmd_rc;
	logic                 cmd_inj;
	logic                 cmd_clr;
	logic                 cmd_del;
	logic                 slot_start;
	logic                 avail;
	logic                 played;
	logic                 ser_stb;
	logic                 net_stb;
	logic [CNT_NUM-1:0]   inc;
	logic                 rc_any;
	logic [8:0]           depth_a;

	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// per-port generator and checker
	// ------------------------------------------------------------
	spl_bert_gen u_gen (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.bert     (bert.gen)
	);
	spl_bert_chk u_chk (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.bert     (bert.chk)
	);

	// ------------------------------------------------------------
	// bus decode and command strobes
	// ------------------------------------------------------------
	assign acc     = wb_cyc_in & wb_stb_in & ~st.ack;
	assign wr      = acc & wb_we_in;
	assign cmd_rc  = wr && wb_adr_in == ADR_CMD && wb_sel_in[0] && wb_dat_in[CMD_RECENTER];
	assign cmd_inj = wr && wb_adr_in == ADR_CMD && wb_sel_in[0] && wb_dat_in[CMD_INJECT];
	assign cmd_clr = wr && wb_adr_in == ADR_CMD && wb_sel_in[0] && wb_dat_in[CMD_CLEAR];
	assign cmd_del = wr && wb_adr_in == ADR_CMD && wb_sel_in[0] && wb_dat_in[CMD_DELETE];

	// playout slot and the bit played toward the serial side
	assign slot_start = st.en && ser_tx_req_in && st.bitcnt == 16'h0000;
	assign avail      = st.depth != 8'h00 && !net_late_in;
	assign played     = (slot_start ? avail : st.play == PLAY_DATA) ?
		net_rx_bit_in : st.fill[st.bitcnt[2:0]];
	assign ser_stb    = st.en && ser_tx_req_in;
	assign net_stb    = st.en && ((st.loop == LOOP_TOWARD_NETWORK) ? ser_tx_req_in
		: ser_rx_valid_in);

	// generator steps with the direction it feeds; checker taps a stream
	assign bert.pattern    = st.pat;
	assign bert.gen_inject = cmd_inj;
	assign bert.gen_adv    = (st.txdir == DIR_NET && net_stb)
		|| (st.txdir == DIR_SERIAL && ser_stb);
	assign bert.chk_valid  = st.en && ((st.rxdir == DIR_NET && ser_tx_req_in)
		|| (st.rxdir == DIR_SERIAL && ser_rx_valid_in));
	assign bert.chk_bit    = (st.rxdir == DIR_NET) ? played : ser_rx_bit_in;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] w;
		logic [CNT_W-1:0] c;
		w       = '0;
		c       = '0;
		next_st = st;
		inc     = '0;
		rc_any  = 1'b0;
		depth_a = {1'b0, st.depth} + {8'h00, st.en & net_pkt_arrive_in};
		next_st.ack          = acc;
		next_st.take         = 1'b0;
		next_st.recenter     = 1'b0;
		next_st.ser_tx_valid = ser_stb;
		next_st.net_tx_valid = net_stb;

		// slot decision: packet or fill for one packet of bits
		if (slot_start && avail) begin
			depth_a          = depth_a - 9'h001;
			next_st.take     = 1'b1;
			next_st.play     = PLAY_DATA;
			next_st.miss_run = 8'h00;
		end else if (slot_start) begin
			next_st.play        = PLAY_FILL;
			inc[CNT_MISSING]    = 1'b1;
			inc[CNT_LATE]       = net_late_in;
			inc[CNT_UNDER]      = st.depth == 8'h00;
			inc[CNT_STARVE]     = st.miss_run == st.thr;
			if (st.miss_run != 8'hff) begin
				next_st.miss_run = st.miss_run + 8'h01;
			end
		end
		if (ser_stb) begin
			next_st.bitcnt = (st.bitcnt == st.pkt_bits - 16'h0001) ? 16'h0000
				: st.bitcnt + 16'h0001;
		end
		inc[CNT_OVER]  = st.en && net_pkt_arrive_in && depth_a > {1'b0, st.maxd};
		inc[CNT_BERR]  = bert.chk_err;
		inc[CNT_BLOSS] = bert.chk_loss;

		// manual or automatic recenter restarts the slot once
		rc_any = cmd_rc || inc[CNT_UNDER] || inc[CNT_OVER] || inc[CNT_STARVE];
		inc[CNT_RECENTER] = rc_any;
		if (rc_any) begin
			next_st.depth    = st.target;
			next_st.bitcnt   = 16'h0000;
			next_st.recenter = 1'b1;
		end else begin
			next_st.depth = depth_a[7:0];
		end

		// data toward serial side and toward network
		if (st.txdir == DIR_SERIAL) begin
			next_st.ser_tx_bit = bert.gen_bit;
		end else if (st.loop == LOOP_TOWARD_SERIAL) begin
			next_st.ser_tx_bit = st.ser_last;
		end else begin
			next_st.ser_tx_bit = played;
		end
		if (st.txdir == DIR_NET) begin
			next_st.net_tx_bit = bert.gen_bit;
		end else if (st.loop == LOOP_TOWARD_NETWORK) begin
			next_st.net_tx_bit = played;
		end else begin
			next_st.net_tx_bit = ser_rx_bit_in;
		end
		if (ser_rx_valid_in) begin
			next_st.ser_last = ser_rx_bit_in;
		end
		if (!ser_stb) begin
			next_st.ser_tx_bit = st.ser_tx_bit;
		end
		if (!net_stb) begin
			next_st.net_tx_bit = st.net_tx_bit;
		end

		// saturating counters; an event in the clear cycle survives
		for (int i = 0; i < CNT_NUM; i++) begin
			c = cmd_clr ? '0 : st.cnt[i];
			if (inc[i] && c != '1) begin
				c = c + 1'b1;
			end
			next_st.cnt[i] = c;
		end

		// register writes; in the first write after delete unwritten bytes take defaults
		if (wr && wb_adr_in == ADR_CTRL) begin
			w = merge(st.del_pend ? CTRL_RST : {21'h0, st.en, st.pat, st.rxdir,
				st.txdir, st.loop}, wb_dat_in, wb_sel_in);
			next_st.loop     = spl_loop_t'(w[CTRL_LOOP_LSB +: 2]);
			next_st.txdir    = spl_dir_t'(w[CTRL_TXDIR_LSB +: 2]);
			next_st.rxdir    = spl_dir_t'(w[CTRL_RXDIR_LSB +: 2]);
			next_st.pat      = spl_pat_t'(w[CTRL_PAT_LSB +: 4]);
			next_st.en       = w[CTRL_EN_BIT];
			next_st.del_pend = 1'b0;
		end else if (wr && wb_adr_in == ADR_BUFCFG) begin
			w = merge(st.del_pend ? BUFCFG_RST : {8'h00, st.thr, st.maxd, st.target},
				wb_dat_in, wb_sel_in);
			next_st.target   = w[7:0];
			next_st.maxd     = w[15:8];
			next_st.thr      = w[23:16];
			next_st.del_pend = 1'b0;
		end else if (wr && wb_adr_in == ADR_PKTCFG) begin
			w = merge(st.del_pend ? PKTCFG_RST : {8'h00, st.fill, st.pkt_bits},
				wb_dat_in, wb_sel_in);
			next_st.pkt_bits = w[15:0];
			next_st.fill     = w[23:16];
			next_st.del_pend = 1'b0;
		end
		if (cmd_del) begin
			next_st.en       = 1'b0;
			next_st.del_pend = 1'b1;
		end

		// read data, unmapped reads zero
		if (wb_adr_in == ADR_CTRL) begin
			next_st.rdata = {21'h0, st.en, st.pat, st.rxdir, st.txdir, st.loop};
		end else if (wb_adr_in == ADR_BUFCFG) begin
			next_st.rdata = {8'h00, st.thr, st.maxd, st.target};
		end else if (wb_adr_in == ADR_PKTCFG) begin
			next_st.rdata = {8'h00, st.fill, st.pkt_bits};
		end else if (wb_adr_in == ADR_STATUS) begin
			next_st.rdata = {21'h0, st.del_pend, st.en, bert.chk_sync, st.depth};
		end else if (wb_adr_in >= ADR_CNT_BASE && wb_adr_in < ADR_CNT_END) begin
			next_st.rdata = 32'(st.cnt[3'((wb_adr_in - ADR_CNT_BASE) >> 2)]);
		end else begin
			next_st.rdata = 32'h0000_0000;
		end
		if (!acc) begin
			next_st.rdata = st.rdata;
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st          <= '0;
			st.pat      <= spl_pat_t'(CTRL_RST[CTRL_PAT_LSB +: 4]);
			st.target   <= BUFCFG_RST[7:0];
			st.maxd     <= BUFCFG_RST[15:8];
			st.thr      <= BUFCFG_RST[23:16];
			st.pkt_bits <= PKTCFG_RST[15:0];
			st.fill     <= PKTCFG_RST[23:16];
		end else begin
			st <= next_st;
		end
	end

	assign wb_dat_out       = st.rdata;
	assign wb_ack_out       = st.ack;
	assign ser_tx_valid_out = st.ser_tx_valid;
	assign ser_tx_bit_out   = st.ser_tx_bit;
	assign net_tx_valid_out = st.net_tx_valid;
	assign net_tx_bit_out   = st.net_tx_bit;
	assign net_pkt_take_out = st.take;
	assign buf_recenter_out = st.recenter;
	assign port_active_out  = st.en;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence slot_miss;
		slot_start && !avail;
	endsequence
	sequence fill_mid;
		st.play == PLAY_FILL && st.bitcnt != 16'h0000;
	endsequence

	fill_subst_a: assert property (slot_miss |=> st.play == PLAY_FILL)
		else $error("missing slot did not select fill");
	fill_length_a: assert property (fill_mid |=> st.play == PLAY_FILL)
		else $error("fill ended inside a packet");
	late_both_a: assert property ((slot_start && net_late_in && !cmd_clr
		&& st.cnt[CNT_MISSING] != '1 && st.cnt[CNT_LATE] != '1)
		|=> st.cnt[CNT_MISSING] == $past(st.cnt[CNT_MISSING]) + 1'b1
		&& st.cnt[CNT_LATE] == $past(st.cnt[CNT_LATE]) + 1'b1)
		else $error("late packet not counted as missing and late");
	recenter_depth_a: assert property (cmd_rc |=> st.depth == $past(st.target)
		&& buf_recenter_out && st.bitcnt == 16'h0000 ##1 !buf_recenter_out)
		else $error("recenter did not load target depth once");
	delete_port_a: assert property (cmd_del |=> !port_active_out && st.del_pend)
		else $error("delete did not disable port");
	loop_none_a: assert property ((ser_stb && st.loop == LOOP_NONE
		&& st.txdir == DIR_OFF) |=> ser_tx_valid_out && ser_tx_bit_out == $past(played))
		else $error("normal flow toward serial broken");
	loop_net_a: assert property ((ser_rx_valid_in && !ser_tx_req_in
		&& st.loop == LOOP_TOWARD_NETWORK) |=> !net_tx_valid_out)
		else $error("serial data leaked toward network in network loop");
	loop_net_ret_a: assert property ((ser_stb && st.loop == LOOP_TOWARD_NETWORK
		&& st.txdir == DIR_OFF) |=> net_tx_valid_out && ser_tx_valid_out
		&& net_tx_bit_out == ser_tx_bit_out)
		else $error("network data not looped and delivered");
	loop_ser_a: assert property ((ser_stb && st.loop == LOOP_TOWARD_SERIAL
		&& st.txdir == DIR_OFF) |=> ser_tx_bit_out == $past(st.ser_last))
		else $error("serial loop did not return serial data");
	bert_tx_a: assert property ((ser_stb && st.txdir == DIR_SERIAL)
		|=> ser_tx_bit_out == $past(bert.gen_bit))
		else $error("generator did not replace serial-bound data");
	clear_cnt_a: assert property ((cmd_clr && !inc[CNT_MISSING])
		|=> st.cnt[CNT_MISSING] == '0)
		else $error("clear left missing counter nonzero");
	starve_a: assert property ((slot_start && !avail && st.miss_run == st.thr)
		|=> buf_recenter_out && st.depth == $past(st.target))
		else $error("starvation did not recenter");
	underflow_a: assert property ((slot_start && st.depth == 8'h00)
		|=> buf_recenter_out ##1 !buf_recenter_out)
		else $error("underflow did not recenter once");
endmodule

// ===== dv/spl_port_core_tb_top.sv
// spl_port_core_tb_top: bus tests of fill, counters and recenter
// assumes spl_term_model drives the serial side of the port
module spl_port_core_tb_top
	import spl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0, rst_b_in = 1'b0, cyc = 1'b0, we = 1'b0, run = 1'b0;
	logic        late = 1'b0, req, rxv, rxb, txv, txb, ack;
	logic [3:0]  sel = 4'hf, bsel = 4'hf;
	logic [7:0]  adr = 8'h00, rx_byte, rx_cnt;
	logic [31:0] dat = 32'h0, rdat, q;
	int          n_fail = 0, num_checks = 0;
	initial forever #5 clk_in = ~clk_in;
	spl_port_core dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.ser_rx_valid_in(rxv), .ser_rx_bit_in(rxb), .ser_tx_req_in(req),
		.ser_tx_valid_out(txv), .ser_tx_bit_out(txb), .net_rx_bit_in(1'b0),
		.net_pkt_arrive_in(1'b0), .net_late_in(late), .net_pkt_take_out(),
		.net_tx_valid_out(), .net_tx_bit_out(), .buf_recenter_out(),
		.port_active_out());
	spl_term_model term_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(run),
		.tx_valid_in(txv), .tx_bit_in(txb), .tx_req_out(req), .rx_valid_out(rxv),
		.rx_bit_out(rxb), .byte_out(rx_byte), .count_out(rx_cnt));
	// ------------------------------------------------------------
	// bus access, comparison and closing
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_in);
		cyc <= 1'b1; we <= w; adr <= a; dat <= d;
		sel <= bsel;
		i = 0;
		do begin @(posedge clk_in); i++; end while (ack !== 1'b1 && i < 50);
		q = rdat;
		cyc <= 1'b0;
		if (i >= 50) begin n_fail++; report_and_stop(); end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		num_checks++;
		if (q !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t adr %h got %h want %h", $time, a, q, e);
		end
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		chk(ADR_CTRL, CTRL_RST);
		chk(ADR_BUFCFG, BUFCFG_RST);
		chk(8'h3c, 32'h0);
		wb(1'b1, ADR_PKTCFG, 32'h005a_0008);
		wb(1'b1, ADR_CTRL, CTRL_RST | 32'h0000_0400);
		late <= 1'b1;
		run <= 1'b1;
		for (int i = 0; i < 200 && rx_cnt < 8'h09; i++) @(posedge clk_in);
		run <= 1'b0;
		repeat (8) @(posedge clk_in);
		// empty buffer: one fill bit, recenter, then a whole fill packet
		num_checks++;
		if (rx_cnt !== 8'h09 || rx_byte !== 8'h5a) begin
			n_fail++;
			$display("CHECK FAILED %0t fill %h bits %0d", $time, rx_byte, rx_cnt);
		end
		chk(8'(ADR_CNT_BASE + 4 * CNT_MISSING), 32'h2);
		chk(8'(ADR_CNT_BASE + 4 * CNT_LATE), 32'h2);
		chk(8'(ADR_CNT_BASE + 4 * CNT_RECENTER), 32'h1);
		chk(8'(ADR_CNT_BASE + 4 * CNT_UNDER), 32'h1);
		wb(1'b1, ADR_CMD, 32'h1 << CMD_CLEAR);
		chk(8'(ADR_CNT_BASE + 4 * CNT_MISSING), 32'h0);
		// disable before a new target, then recenter onto it
		wb(1'b1, ADR_CTRL, CTRL_RST);
		wb(1'b1, ADR_BUFCFG, 32'h0003_2007);
		wb(1'b1, ADR_CMD, 32'h1 << CMD_RECENTER);
		chk(ADR_STATUS, 32'h0000_0007);
		chk(8'(ADR_CNT_BASE + 4 * CNT_RECENTER), 32'h1);
		// delete, then a one-lane write leaves other lanes at defaults
		wb(1'b1, ADR_CMD, 32'h1 << CMD_DELETE);
		chk(ADR_STATUS, 32'h0000_0407);
		bsel = 4'h1;
		wb(1'b1, ADR_BUFCFG, 32'h0000_0009);
		bsel = 4'hf;
		chk(ADR_BUFCFG, 32'h0005_1009);
		// generator and checker on one pattern, terminal echoes bits
		wb(1'b1, ADR_CTRL, 32'h0000_0528);
		run <= 1'b1;
		repeat (400) @(posedge clk_in);
		wb(1'b0, ADR_STATUS, 32'h0);
		num_checks++;
		if (q[9:8] !== 2'b11) begin
			n_fail++;
			$display("CHECK FAILED %0t checker not in sync", $time);
		end
		wb(1'b1, ADR_CMD, 32'h1 << CMD_INJECT);
		repeat (16) @(posedge clk_in);
		run <= 1'b0;
		repeat (8) @(posedge clk_in);
		chk(8'(ADR_CNT_BASE + 4 * CNT_BERR), 32'h1);
		chk(8'(ADR_CNT_BASE + 4 * CNT_BLOSS), 32'h0);
		report_and_stop();
	end
endmodule

// ===== dv/spl_term_model.sv
// spl_term_model: serial terminal beside the port, strobes playout bits
// assumes it shares clk_in and rst_b_in with the port core
module spl_term_model (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       run_in,
	input  wire logic       tx_valid_in,
	input  wire logic       tx_bit_in,
	output logic            tx_req_out,
	output logic            rx_valid_out,
	output logic            rx_bit_out,
	output logic [7:0]      byte_out,
	output logic [7:0]      count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase;
	// ------------------------------------------------------------
	// strobe every fourth cycle; data line toggles when idle
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			{phase, tx_req_out, rx_valid_out, rx_bit_out, byte_out, count_out} <= '0;
		end else begin
			phase <= phase + 2'h1;
			tx_req_out <= run_in && phase == 2'h0;
			rx_valid_out <= run_in && phase == 2'h2;
			// echo a played bit back, otherwise toggle so no stale bit shows
			rx_bit_out <= tx_valid_in ? tx_bit_in : ~rx_bit_out;
			if (tx_valid_in) begin
				byte_out <= {tx_bit_in, byte_out[7:1]}; // bit0 first
				count_out <= count_out + 8'h1;
			end
		end
	end
endmodule
